// ==== sleep_wake_pkg.sv ====
package sleep_wake_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] WDT_OFS    = 8'h08;

  localparam int CTRL_WDT_EN_BIT  = 0;
  localparam int CTRL_WAKE_EN_BIT = 1;
  localparam int CTRL_MASTER_CLEAR_IN_EN_BIT = 2;

  localparam int STATUS_SLEEP_BIT = 0;
  localparam int STATUS_PD_BIT    = 3;
  localparam int STATUS_TO_BIT    = 4;
  localparam int STATUS_WAKE_BIT  = 7;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [2:0] CTRL_RST = 3'h7;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ         = 100_000_000;
  localparam int CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
  localparam int DRT_POR_US     = 18_000;
  localparam int DRT_WARM_NS    = 10_000;
  localparam int WDT_PERIOD_US  = 18_000;
  localparam int DRT_POR_CYC    = DRT_POR_US * (CLK_HZ / 1_000_000);
  localparam int DRT_WARM_CYC   = DRT_WARM_NS / CLK_PERIOD_NS;
  localparam int WDT_PERIOD_CYC = WDT_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int WAKE_PINS      = 4;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    ST_DRT   = 2'b00,
    ST_RUN   = 2'b01,
    ST_SLEEP = 2'b10
  } pwr_state_t;

  typedef struct packed {
    logic master_clear_in_en;
    logic wake_en;
    logic wdt_en;
  } ctrl_t;

  typedef struct packed {
    logic wake_change_flag;
    logic timeout_flag_n;
    logic powerdown_flag_n;
  } flags_t;

  localparam flags_t FLAGS_POR = 3'h3;

endpackage

// ==== wdt_timer.sv ====
`timescale 1ns/1ps

module wdt_timer
  import sleep_wake_pkg::*;
#(
  parameter int CYCLES = WDT_PERIOD_CYC,
  parameter int CNT_W  = $clog2(CYCLES) + 1
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  // Control
  input  wire logic             enable,
  input  wire logic             clear,
  // Status
  output logic                  timeout,
  output logic [CNT_W-1:0]      count
);

  // ==========================================================================
  // Counter
  // ==========================================================================
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  // The counter must hold CYCLES - 1, or the expiry count would be cut short.
  if (CYCLES < 2 || CNT_W < $clog2(CYCLES)) begin : g_bad_cycles
    $error("wdt_timer: CYCLES below 2 or CNT_W too narrow");
  end

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic             timeout_r;
  logic             timeout_nxt;

  always_comb begin
    count_nxt   = count_r;
    timeout_nxt = 1'b0;
    if (clear || !enable) begin
      count_nxt = '0;
    end else if (count_r == LAST) begin
      count_nxt   = '0;
      timeout_nxt = 1'b1;
    end else begin
      count_nxt = count_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r   <= '0;
      timeout_r <= 1'b0;
    end else if (clk_en) begin
      count_r   <= count_nxt;
      timeout_r <= timeout_nxt;
    end
  end

  assign count   = count_r;
  assign timeout = timeout_r;

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_wdt_period: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(timeout_r) |-> $past(count_r) == LAST && count_r == '0)
    else $error("watchdog expired at the wrong count");

endmodule // wdt_timer

// ==== sleep_wake_control.sv ====
`timescale 1ns/1ps

module sleep_wake_control
  import sleep_wake_pkg::*;
#(
  parameter int PIN_COUNT       = WAKE_PINS,
  parameter int DRT_POR_CYCLES  = DRT_POR_CYC,
  parameter int DRT_WARM_CYCLES = DRT_WARM_CYC,
  parameter int WDT_CYCLES      = WDT_PERIOD_CYC
) (
  // Clock, reset and enable
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 clk_en,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Core events
  input  wire logic                 sleep_exec,
  input  wire logic                 clrwdt_exec,
  input  wire logic                 port_access,
  // Pins
  input  wire logic                 master_clear_in,
  input  wire logic [PIN_COUNT-1:0] wake_pins,
  output logic                      master_clear_in_oe,
  // Power control
  output logic                      core_reset,
  output logic                      core_clk_en,
  output logic                      osc_drive_en,
  output logic                      io_hold
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  localparam int DRT_MAX = (DRT_POR_CYCLES > DRT_WARM_CYCLES) ? DRT_POR_CYCLES
                                                                : DRT_WARM_CYCLES;
  localparam int DRT_W   = $clog2(DRT_MAX) + 1;
  localparam int WDT_W   = $clog2(WDT_CYCLES) + 1;
  localparam logic [DRT_W-1:0] DRT_POR_LOAD  = DRT_W'(DRT_POR_CYCLES - 1);
  localparam logic [DRT_W-1:0] DRT_WARM_LOAD = DRT_W'(DRT_WARM_CYCLES - 1);

  if (PIN_COUNT < 1 || PIN_COUNT > 8 || DRT_POR_CYCLES < 1 || DRT_WARM_CYCLES < 1
      || WDT_W > 32) begin : g_bad_params
    $error("sleep_wake_control: unsupported parameter values");
  end

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // The pins are asynchronous to pclk, and pclk is the clock that keeps
  // running while the core clock is gated off in sleep.
  localparam int SYNC_W = PIN_COUNT + 1;

  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [SYNC_W-1:0] pins_raw;

  assign pins_raw = {master_clear_in, wake_pins};

  for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1_r[i] <= 1'b1;
        sync2_r[i] <= 1'b1;
      end else if (clk_en) begin
        sync1_r[i] <= pins_raw[i];
        sync2_r[i] <= sync1_r[i];
      end
    end
  end

  ctrl_t                ctrl_r;
  logic                 master_clear_in_low;
  logic [PIN_COUNT-1:0] pins_s;

  assign master_clear_in_low = ctrl_r.master_clear_in_en && !sync2_r[PIN_COUNT];
  assign pins_s   = sync2_r[PIN_COUNT-1:0];

  // ==========================================================================
  // Port snapshot
  // ==========================================================================
  // Any port file or bit operation refreshes the snapshot; a stale snapshot
  // left from before sleep makes the device wake at once.
  logic [PIN_COUNT-1:0] snap_r;
  logic [PIN_COUNT-1:0] snap_nxt;
  logic                 pin_mismatch;

  always_comb begin
    snap_nxt = snap_r;
    if (port_access) begin
      snap_nxt = pins_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_r <= '1;
    end else if (clk_en) begin
      snap_r <= snap_nxt;
    end
  end

  assign pin_mismatch = |(pins_s ^ snap_r);

  // ==========================================================================
  // Watchdog
  // ==========================================================================
  pwr_state_t       state_r;
  pwr_state_t       state_nxt;
  logic             wdt_clear;
  logic             wdt_to;
  logic [WDT_W-1:0] wdt_count;

  wdt_timer #(
    .CYCLES  (WDT_CYCLES),
    .CNT_W   (WDT_W)
  ) u_wdt (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .enable  (ctrl_r.wdt_en),
    .clear   (wdt_clear),
    .timeout (wdt_to),
    .count   (wdt_count)
  );

  // ==========================================================================
  // Power sequencer
  // ==========================================================================
  flags_t           flags_r;
  flags_t           flags_nxt;
  logic [DRT_W-1:0] drt_r;
  logic [DRT_W-1:0] drt_nxt;

  always_comb begin
    state_nxt = state_r;
    flags_nxt = flags_r;
    drt_nxt   = drt_r;
    wdt_clear = clrwdt_exec;
    case (state_r)
      ST_DRT: begin
        wdt_clear = 1'b1;
        if (master_clear_in_low) begin
          drt_nxt = DRT_WARM_LOAD;
        end else if (drt_r == '0) begin
          state_nxt = ST_RUN;
        end else begin
          drt_nxt = drt_r - 1'b1;
        end
      end
      ST_RUN: begin
        if (master_clear_in_low) begin
          // Flags keep their values across a master-clear pulse.
          state_nxt = ST_DRT;
          drt_nxt   = DRT_WARM_LOAD;
        end else if (wdt_to) begin
          state_nxt                = ST_DRT;
          drt_nxt                  = DRT_WARM_LOAD;
          flags_nxt.timeout_flag_n = 1'b0;
          flags_nxt.wake_change_flag = 1'b0;
        end else if (sleep_exec) begin
          state_nxt                  = ST_SLEEP;
          wdt_clear                  = 1'b1;
          flags_nxt.timeout_flag_n   = 1'b1;
          flags_nxt.powerdown_flag_n = 1'b0;
        end
      end
      ST_SLEEP: begin
        // Each wake source restarts the core through the reset timer.
        if (master_clear_in_low) begin
          state_nxt = ST_DRT;
          drt_nxt   = DRT_WARM_LOAD;
          wdt_clear = 1'b1;
        end else if (wdt_to) begin
          state_nxt                  = ST_DRT;
          drt_nxt                    = DRT_WARM_LOAD;
          wdt_clear                  = 1'b1;
          flags_nxt.timeout_flag_n   = 1'b0;
          flags_nxt.wake_change_flag = 1'b0;
        end else if (ctrl_r.wake_en && pin_mismatch) begin
          state_nxt                  = ST_DRT;
          drt_nxt                    = DRT_WARM_LOAD;
          wdt_clear                  = 1'b1;
          flags_nxt.wake_change_flag = 1'b1;
          flags_nxt.timeout_flag_n   = 1'b1;
          flags_nxt.powerdown_flag_n = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_DRT;
        drt_nxt   = DRT_WARM_LOAD;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_DRT;
      flags_r <= FLAGS_POR;
      drt_r   <= DRT_POR_LOAD;
    end else if (clk_en) begin
      state_r <= state_nxt;
      flags_r <= flags_nxt;
      drt_r   <= drt_nxt;
    end
  end

  // The watchdog reset stays inside; the master-clear pin is input only.
  assign master_clear_in_oe      = 1'b0;
  assign core_reset   = (state_r == ST_DRT);
  assign core_clk_en  = (state_r == ST_RUN);
  assign osc_drive_en = (state_r != ST_SLEEP);
  assign io_hold      = (state_r == ST_SLEEP);

  // ==========================================================================
  // APB registers
  // ==========================================================================
  logic        addr_hit;
  logic        wr_en;
  logic [31:0] rd_data;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  ctrl_t       ctrl_nxt;

  assign addr_hit = (paddr == CTRL_OFS) || (paddr == STATUS_OFS) || (paddr == WDT_OFS);
  assign wr_en    = psel && penable && pwrite && (paddr == CTRL_OFS);

  always_comb begin
    rd_data = 32'h0000_0000;
    case (paddr)
      CTRL_OFS: begin
        rd_data[2:0] = ctrl_r;
      end
      STATUS_OFS: begin
        rd_data[STATUS_SLEEP_BIT] = (state_r == ST_SLEEP);
        rd_data[STATUS_PD_BIT]    = flags_r.powerdown_flag_n;
        rd_data[STATUS_TO_BIT]    = flags_r.timeout_flag_n;
        rd_data[STATUS_WAKE_BIT]  = flags_r.wake_change_flag;
      end
      WDT_OFS: begin
        rd_data[WDT_W-1:0] = wdt_count;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    ctrl_nxt   = ctrl_r;
    prdata_nxt = prdata_r;
    if (wr_en) begin
      ctrl_nxt.wdt_en  = pwdata[CTRL_WDT_EN_BIT];
      ctrl_nxt.wake_en = pwdata[CTRL_WAKE_EN_BIT];
      ctrl_nxt.master_clear_in_en = pwdata[CTRL_MASTER_CLEAR_IN_EN_BIT];
    end
    if (psel && !penable && !pwrite) begin
      prdata_nxt = rd_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= CTRL_RST;
      prdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
      ctrl_r   <= ctrl_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Zero wait states: the read word was captured in the setup cycle.
  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_hit;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_sleep_by_cmd: assert property (
    $rose(state_r == ST_SLEEP) |-> $past(sleep_exec) && $past(state_r) == ST_RUN)
    else $error("sleep entered without the power-down instruction");

  chk_sleep_entry: assert property (
    $rose(state_r == ST_SLEEP) |-> flags_r.timeout_flag_n && !flags_r.powerdown_flag_n
      && wdt_count == '0)
    else $error("sleep entry left flags or watchdog wrong");

  chk_osc_off: assert property (
    state_r == ST_SLEEP |-> !osc_drive_en && !core_clk_en && io_hold)
    else $error("oscillator or pins not held during sleep");

  chk_master_clear_in_quiet: assert property (
    wdt_to |-> ##[0:2] !master_clear_in_oe)
    else $error("master-clear pin driven by the device");

  chk_master_clear_in_wake: assert property (
    state_r == ST_SLEEP && master_clear_in_low && clk_en |=> core_reset && $stable(flags_r))
    else $error("master-clear did not wake the device");

  chk_wdt_wake: assert property (
    state_r == ST_SLEEP && wdt_to && !master_clear_in_low && clk_en
      |=> core_reset && !flags_r.timeout_flag_n && drt_r == DRT_WARM_LOAD)
    else $error("watchdog wake did not restart the reset timer");

  chk_pin_wake: assert property (
    state_r == ST_SLEEP && clk_en && ctrl_r.wake_en && pin_mismatch && !master_clear_in_low && !wdt_to
      |=> core_reset && flags_r == 3'h6)
    else $error("pin-change wake flags wrong");

  chk_wake_is_reset: assert property (
    $fell(state_r == ST_SLEEP) |-> state_r == ST_DRT && wdt_count == '0)
    else $error("sleep left without a full reset");

  chk_master_clear_in_flags: assert property (
    master_clear_in_low && clk_en && state_r != ST_SLEEP |=> $stable(flags_r))
    else $error("master-clear pulse changed the flags");

  chk_no_early_wake: assert property (
    state_r == ST_SLEEP && clk_en && !master_clear_in_low && !wdt_to && !pin_mismatch
      |=> state_r == ST_SLEEP)
    else $error("device woke without a cause");

  cov_sleep: cover property ($rose(state_r == ST_SLEEP));
  cov_wdt_wake: cover property (state_r == ST_SLEEP && wdt_to ##1 core_reset);
  cov_pin_wake: cover property ($rose(flags_r.wake_change_flag));
  cov_master_clear_in_wake: cover property (state_r == ST_SLEEP && master_clear_in_low ##1 core_reset);

endmodule // sleep_wake_control

// ==== ext_pins.sv ====
`timescale 1ns/1ps

// ============================================================================
// Outside party: reset switch on the master-clear pin and the four wake pins
// ============================================================================
module ext_pins (
  // Clock
  input  wire logic       pclk,
  // Requests from the bench
  input  wire logic       master_clear_in_req,
  input  wire logic [3:0] pin_set,
  // Pins
  output logic            master_clear_in = 1'b1,
  output logic [3:0]      wake_pins       = 4'h0
);
  // The pin has a pull-up, so it rests high whenever the switch is open.
  always @(posedge pclk) begin
    master_clear_in <= ~master_clear_in_req;
    wake_pins       <= pin_set;
  end
endmodule // ext_pins

// ==== sleep_wake_control_test.sv ====
`timescale 1ns/1ps

module sleep_wake_control_test;
  import sleep_wake_pkg::*;

  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        pclk, presetn, clk_en, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, last_err;
  logic        sleep_exec, clrwdt_exec, port_access, master_clear_in_req;
  logic [3:0]  pin_set, wake_pins;
  logic        master_clear_in, master_clear_in_oe, core_reset, core_clk_en, osc_drive_en, io_hold;
  int          miscompares, comparisons;

  sleep_wake_control #(.PIN_COUNT(4), .DRT_POR_CYCLES(20), .DRT_WARM_CYCLES(5),
                       .WDT_CYCLES(50)) u_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_exec(sleep_exec), .clrwdt_exec(clrwdt_exec),
    .port_access(port_access), .master_clear_in(master_clear_in), .wake_pins(wake_pins),
    .master_clear_in_oe(master_clear_in_oe), .core_reset(core_reset), .core_clk_en(core_clk_en),
    .osc_drive_en(osc_drive_en), .io_hold(io_hold));

  ext_pins u_pins (.pclk(pclk), .master_clear_in_req(master_clear_in_req), .pin_set(pin_set),
                   .master_clear_in(master_clear_in), .wake_pins(wake_pins));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] st(input logic w, input logic t, input logic p,
                                     input logic s);
    st                   = 32'h0;
    st[STATUS_WAKE_BIT]  = w;
    st[STATUS_TO_BIT]    = t;
    st[STATUS_PD_BIT]    = p;
    st[STATUS_SLEEP_BIT] = s;
  endfunction

  // Waits for core_reset (sel 0) or core_clk_en (sel 1) under a bound.
  task automatic wait_lvl(input logic sel, input int lim);
    int n;
    n = 0;
    while (((sel ? core_clk_en : core_reset) !== 1'b1) && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk("wait_level", 32'h1, {31'h0, sel ? core_clk_en : core_reset});
  endtask

  // Clears the watchdog, snapshots the port, then executes the power-down.
  task automatic enter_sleep;
    @(posedge pclk);
    clrwdt_exec <= 1'b1;
    port_access <= 1'b1;
    @(posedge pclk);
    clrwdt_exec <= 1'b0;
    port_access <= 1'b0;
    sleep_exec  <= 1'b1;
    @(posedge pclk);
    sleep_exec  <= 1'b0;
    @(posedge pclk);
    #1;
  endtask

  task automatic stop_test;
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Clock and watchdog
  // ==========================================================================
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    stop_test();
  end

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    miscompares = 0;
    comparisons = 0;
    {presetn, psel, penable, pwrite, sleep_exec, clrwdt_exec, port_access} = 7'h0;
    {paddr, pwdata, master_clear_in_req} = 41'h0;
    clk_en  = 1'b1;
    pin_set = 4'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wait_lvl(1'b1, 300);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl_reset", 32'h7, rd);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status_por", st(0, 1, 1, 0), rd);
    chk("no_sleep", 32'h1, {31'h0, osc_drive_en & ~io_hold});
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, last_err});
    chk("unmapped_data", 32'h0, rd);
    chk("pready", 32'h1, {31'h0, pready});
    apb(1'b1, STATUS_OFS, 32'h0);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status_ro", st(0, 1, 1, 0), rd);
    // Pin-change wake-up.
    pin_set <= 4'h5;
    repeat (5) @(posedge pclk);
    enter_sleep();
    chk("io_hold", 32'h1, {31'h0, io_hold});
    chk("osc_off", 32'h0, {31'h0, osc_drive_en});
    chk("clk_off", 32'h0, {31'h0, core_clk_en});
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status_sleep", st(0, 1, 0, 1), rd);
    apb(1'b0, WDT_OFS, 32'h0);
    chk("wdt_cleared", 32'h1, {31'h0, rd < 32'h8});
    pin_set <= 4'h1;
    wait_lvl(1'b0, 20);
    wait_lvl(1'b1, 40);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status_pin", st(1, 1, 0, 0), rd);
    apb(1'b0, WDT_OFS, 32'h0);
    chk("wdt_wake_clr", 32'h1, {31'h0, rd < 32'h14});
    // Watchdog wake-up.
    enter_sleep();
    wait_lvl(1'b0, 200);
    chk("master_clear_in_quiet", 32'h0, {31'h0, master_clear_in_oe});
    wait_lvl(1'b1, 40);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status_wdt", st(0, 0, 0, 0), rd);
    // Master-clear wake-up with the pin wake and watchdog disabled.
    apb(1'b1, CTRL_OFS, 32'h4);
    enter_sleep();
    pin_set <= 4'h3;
    repeat (100) @(posedge pclk);
    #1;
    chk("no_pin_wake", 32'h1, {31'h0, io_hold});
    master_clear_in_req <= 1'b1;
    wait_lvl(1'b0, 20);
    master_clear_in_req <= 1'b0;
    wait_lvl(1'b1, 40);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status_master_clear_in", st(0, 1, 0, 0), rd);
    chk("master_clear_in_oe", 32'h0, {31'h0, master_clear_in_oe});
    stop_test();
  end
endmodule // sleep_wake_control_test
